// file: verilog/ssf_regs.svh
// register map, field positions and reset values of the spi status flag block
`ifndef SSF_REGS_SVH
`define SSF_REGS_SVH

`define SSF_ADDR_W        12
`define SSF_STATUS_IDX    8'h99
`define SSF_RXDATA_IDX    8'h9A
`define SSF_TXDATA_IDX    8'h9B
`define SSF_CTRL_IDX      8'hA0
`define SSF_STATUS_ADDR   {2'b00, `SSF_STATUS_IDX, 2'b00}
`define SSF_RXDATA_ADDR   {2'b00, `SSF_RXDATA_IDX, 2'b00}
`define SSF_TXDATA_ADDR   {2'b00, `SSF_TXDATA_IDX, 2'b00}
`define SSF_CTRL_ADDR     {2'b00, `SSF_CTRL_IDX, 2'b00}

`define SSF_CTRL_RXIE     0
`define SSF_CTRL_RXIE_ALT 1
`define SSF_CTRL_TXIE     2
`define SSF_CTRL_EXP_EN   3
`define SSF_CTRL_W        4
`define SSF_CTRL_RST      4'h0

`define SSF_FIFO_DEPTH    12
`define SSF_PTR_ZERO      4'h0
`define SSF_CNT_ZERO      4'h0
`define SSF_BITS_LAST     3'h7
`define SSF_BITS_ZERO     3'h0
`define SSF_IDLE_BYTE     8'hFF
`define SSF_RSVD_BITS     2'h0

`endif

// file: verilog/ssf_pkg.sv
// types shared by the spi status flag block
`default_nettype none
package ssf_pkg;
   // order gives the status byte layout, bit 7 first, two reserved bits last
   typedef struct packed {
      logic       rx_overrun_flag;
      logic       rx_not_empty_flag;
      logic       tx_full_flag;
      logic       tx_empty_flag;
      logic       tx_flush_flag;
      logic       expander_detect_flag;
      logic [1:0] reserved;
   } ssf_status_t;

   typedef struct packed {
      logic sck;
      logic mosi;
      logic ss_n;
   } ssf_pins_t;
endpackage
`default_nettype wire

// file: verilog/ssf_sync.sv
// two flip-flop synchroniser for a group of pin inputs
`timescale 1ns/1ns
`default_nettype none
module ssf_sync #(
   parameter int WIDTH = 1
) (
   input  wire logic             pclk,
   input  wire logic             presetn,
   input  wire logic [WIDTH-1:0] din,
   input  wire logic [WIDTH-1:0] rst_val,
   output var  logic [WIDTH-1:0] dout
);
   logic [WIDTH-1:0] meta;
   logic [WIDTH-1:0] sync2;
   logic [1:0]       arm;

   // async reset may only load constants; idle level shows until both stages hold pin data
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         meta  <= '0;
         sync2 <= '0;
         arm   <= 2'h0;
      end else begin
         meta  <= din;
         sync2 <= meta;
         arm   <= {arm[0], 1'b1};
      end
   end

   // without the mux a reset value of zero would look like a select edge
   assign dout = arm[1] ? sync2 : rst_val;
endmodule // ssf_sync
`default_nettype wire

// file: verilog/ssf_top.sv
// spi status flags, receive and transmit fifos, slave-side shifter and apb registers
//
// Overview of operation
// - overrun flag on write into full receive fifo
// - overrunning byte is discarded
// - overrun raises receive interrupt when enabled
// - status write while overrun is set clears it and empties receive fifo, unless a byte completes into the full fifo in that cycle
// - overrun freezes write pointer, stores nothing
// - core reads keep working during overrun
// - not-empty follows the receive count, cleared when drained
// - not-empty raises receive interrupt when enabled
// - full on core write filling; cleared on spi read
// - empty on spi read draining; set at reset
// - flush when select rises with data pending
// - flush zeroes both hidden transmit pointers
// - transmit data write clears flush flag
// - transmit interrupt while pointers equal and empty
// - expander flag after first byte when mosi low
// - expander flag cleared on select rising edge
// - status register read-only, writes store nothing
// - twelve-byte fifos, pointers wrap, never decrement
// - clearing overrun zeroes both receive pointers
`timescale 1ns/1ns
`default_nettype none
`include "ssf_regs.svh"
module ssf_top
   import ssf_pkg::*;
#(
   parameter int DEPTH = `SSF_FIFO_DEPTH
) (
   input  wire logic                  pclk,
   input  wire logic                  presetn,
   input  wire logic                  psel,
   input  wire logic                  penable,
   input  wire logic                  pwrite,
   input  wire logic [`SSF_ADDR_W-1:0] paddr,
   input  wire logic [31:0]           pwdata,
   output var  logic [31:0]           prdata,
   output var  logic                  pready,
   output var  logic                  pslverr,
   input  wire logic                  sck,
   input  wire logic                  mosi,
   input  wire logic                  ss_n,
   output var  logic                  miso,
   output var  logic                  miso_oe,
   output var  logic                  rx_irq,
   output var  logic                  tx_irq
);
   ssf_pins_t   pins_s;
   ssf_pins_t   pins_idle;
   logic        sck_d, ss_d;
   ssf_status_t st, next_st;
   logic [`SSF_CTRL_W-1:0] ctrl, next_ctrl;
   logic [7:0]  rx_mem [DEPTH];
   logic [7:0]  tx_mem [DEPTH];
   logic [7:0]  next_rx_mem [DEPTH];
   logic [7:0]  next_tx_mem [DEPTH];
   logic [3:0]  rx_write_ptr, rx_read_ptr, tx_write_ptr, tx_read_ptr;
   logic [3:0]  next_rx_write_ptr, next_rx_read_ptr, next_tx_write_ptr, next_tx_read_ptr;
   logic [3:0]  rx_cnt, tx_cnt, next_rx_cnt, next_tx_cnt;
   logic [7:0]  rx_shift, tx_shift, next_rx_shift, next_tx_shift;
   logic [2:0]  bit_cnt, next_bit_cnt;
   logic        tx_loaded, tx_busy, exp_mode, exp_done;
   logic        next_tx_loaded, next_tx_busy, next_exp_mode, next_exp_done;
   logic [31:0] next_prdata;
   logic        next_pready, next_pslverr, next_miso, next_miso_oe, next_rx_irq, next_tx_irq;

   logic sck_rise, sck_fall, ss_fall, ss_rise, selected, byte_done;
   logic apb_setup, apb_done, wr_status, wr_rxdata, wr_txdata, wr_ctrl, rd_rxdata;
   logic [7:0] rx_byte;

   function automatic logic [3:0] ptr_inc(input logic [3:0] p);
      ptr_inc = (p == 4'(DEPTH - 1)) ? `SSF_PTR_ZERO : 4'(p + 4'h1);
   endfunction

   assign pins_idle = '{sck: 1'b0, mosi: 1'b1, ss_n: 1'b1};

   // pins cross into the core clock before anything looks at them
   ssf_sync #(.WIDTH(3)) u_sync (
      .pclk    (pclk),
      .presetn (presetn),
      .din     ({sck, mosi, ss_n}),
      .rst_val (pins_idle),
      .dout    (pins_s)
   );

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sck_d <= 1'b0;
         ss_d  <= 1'b1;
      end else begin
         sck_d <= pins_s.sck;
         ss_d  <= pins_s.ss_n;
      end
   end

   always_comb begin
      selected  = ~pins_s.ss_n;
      sck_rise  = pins_s.sck & ~sck_d & selected;
      sck_fall  = ~pins_s.sck & sck_d & selected;
      ss_fall   = ~pins_s.ss_n & ss_d;
      ss_rise   = pins_s.ss_n & ~ss_d;
      byte_done = sck_rise & (bit_cnt == `SSF_BITS_LAST);
      rx_byte   = {rx_shift[6:0], pins_s.mosi};
      apb_setup = psel & ~penable;
      apb_done  = psel & penable & pready;
      wr_status = apb_done & pwrite & (paddr == `SSF_STATUS_ADDR);
      wr_rxdata = apb_done & pwrite & (paddr == `SSF_RXDATA_ADDR);
      wr_txdata = apb_done & pwrite & (paddr == `SSF_TXDATA_ADDR);
      wr_ctrl   = apb_done & pwrite & (paddr == `SSF_CTRL_ADDR);
      rd_rxdata = apb_done & ~pwrite & (paddr == `SSF_RXDATA_ADDR);
   end

   // shifter: samples mosi on sck rise, shifts miso on sck fall, msb first
   always_comb begin
      next_rx_shift = rx_shift;
      next_tx_shift = tx_shift;
      next_bit_cnt  = bit_cnt;
      next_tx_loaded = tx_loaded;
      next_tx_busy  = tx_busy;
      next_exp_mode = exp_mode;
      next_exp_done = exp_done;
      if (sck_rise) begin
         next_rx_shift = rx_byte;
         next_bit_cnt  = 3'(bit_cnt + 3'h1);
         if (bit_cnt == `SSF_BITS_ZERO && tx_loaded)
            next_tx_busy = 1'b1;
      end
      // no shift right after a byte boundary, the fresh msb is already on miso
      if (sck_fall && bit_cnt != `SSF_BITS_ZERO)
         next_tx_shift = {tx_shift[6:0], 1'b1};
      if (byte_done) begin
         next_tx_busy = 1'b0;
         if (exp_mode)
            next_exp_done = 1'b1;
      end
      if (ss_fall || byte_done) begin
         next_tx_loaded = ~st.tx_empty_flag;
         next_tx_shift  = st.tx_empty_flag ? `SSF_IDLE_BYTE : tx_mem[tx_read_ptr];
      end
      if (ss_fall)
         next_exp_mode = ctrl[`SSF_CTRL_EXP_EN] & ~pins_s.mosi;
      if (pins_s.ss_n) begin
         next_bit_cnt  = `SSF_BITS_ZERO;
         next_tx_busy  = 1'b0;
         next_exp_mode = 1'b0;
         next_exp_done = 1'b0;
      end
   end

   // receive fifo
   always_comb begin
      next_rx_mem       = rx_mem;
      next_rx_write_ptr = rx_write_ptr;
      next_rx_read_ptr  = rx_read_ptr;
      next_rx_cnt       = rx_cnt;
      next_st.rx_overrun_flag = st.rx_overrun_flag;
      if (wr_rxdata)
         next_rx_mem[rx_read_ptr] = pwdata[7:0];
      if (rd_rxdata && rx_cnt != `SSF_CNT_ZERO) begin
         next_rx_read_ptr = ptr_inc(rx_read_ptr);
         next_rx_cnt      = 4'(next_rx_cnt - 4'h1);
      end
      // expander bytes belong to the port, not the fifo
      if (byte_done && !exp_mode && !exp_done) begin
         if (rx_cnt == 4'(DEPTH)) begin
            next_st.rx_overrun_flag = 1'b1;
         end else if (!st.rx_overrun_flag) begin
            next_rx_mem[rx_write_ptr] = rx_byte;
            next_rx_write_ptr = ptr_inc(rx_write_ptr);
            next_rx_cnt       = 4'(next_rx_cnt + 4'h1);
         end
      end
      // a fresh overrun in the same cycle outlasts the clear
      if (wr_status && st.rx_overrun_flag && next_st.rx_overrun_flag == st.rx_overrun_flag
          && !(byte_done && rx_cnt == 4'(DEPTH))) begin
         next_st.rx_overrun_flag = 1'b0;
         next_rx_write_ptr = `SSF_PTR_ZERO;
         next_rx_read_ptr  = `SSF_PTR_ZERO;
         next_rx_cnt       = `SSF_CNT_ZERO;
      end
      next_st.rx_not_empty_flag = (next_rx_cnt != `SSF_CNT_ZERO);
   end

   // transmit fifo and flags; pointers are never visible on the bus
   always_comb begin
      next_tx_mem       = tx_mem;
      next_tx_write_ptr = tx_write_ptr;
      next_tx_read_ptr  = tx_read_ptr;
      next_tx_cnt       = tx_cnt;
      next_st.tx_full_flag  = st.tx_full_flag;
      next_st.tx_empty_flag = st.tx_empty_flag;
      next_st.tx_flush_flag = st.tx_flush_flag;
      // writes into a full fifo are dropped rather than overwriting unsent data
      if (wr_txdata && !st.tx_full_flag) begin
         next_tx_mem[tx_write_ptr] = pwdata[7:0];
         next_tx_write_ptr = ptr_inc(tx_write_ptr);
         next_tx_cnt       = 4'(next_tx_cnt + 4'h1);
         next_st.tx_empty_flag = 1'b0;
      end
      if (wr_txdata)
         next_st.tx_flush_flag = 1'b0;
      if (sck_rise && bit_cnt == `SSF_BITS_ZERO && tx_loaded) begin
         next_tx_read_ptr = ptr_inc(tx_read_ptr);
         next_tx_cnt      = 4'(next_tx_cnt - 4'h1);
      end
      if (next_tx_cnt == 4'(DEPTH))
         next_st.tx_full_flag = 1'b1;
      else
         next_st.tx_full_flag = 1'b0;
      if (next_tx_cnt == `SSF_CNT_ZERO)
         next_st.tx_empty_flag = 1'b1;
      if (ss_rise && (tx_cnt != `SSF_CNT_ZERO || tx_busy)) begin
         next_tx_write_ptr = `SSF_PTR_ZERO;
         next_tx_read_ptr  = `SSF_PTR_ZERO;
         next_tx_cnt       = `SSF_CNT_ZERO;
         next_st.tx_flush_flag = 1'b1;
         next_st.tx_empty_flag = 1'b1;
         next_st.tx_full_flag  = 1'b0;
      end
   end

   // expander flag, status reserved bits, irq and pin outputs
   always_comb begin
      next_st.expander_detect_flag = st.expander_detect_flag;
      if (byte_done && exp_mode && !exp_done)
         next_st.expander_detect_flag = 1'b1;
      if (ss_rise)
         next_st.expander_detect_flag = 1'b0;
      next_st.reserved = `SSF_RSVD_BITS;
      next_rx_irq = (next_st.rx_overrun_flag & ctrl[`SSF_CTRL_RXIE])
                  | (next_st.rx_not_empty_flag & ctrl[`SSF_CTRL_RXIE_ALT]);
      next_tx_irq = ctrl[`SSF_CTRL_TXIE] & next_st.tx_empty_flag
                  & (next_tx_read_ptr == next_tx_write_ptr);
      next_miso    = next_tx_shift[7];
      next_miso_oe = ~pins_s.ss_n;
   end

   // apb slave: one wait-free access phase, data latched at setup
   always_comb begin
      next_ctrl    = ctrl;
      next_pready  = apb_setup;
      next_pslverr = 1'b0;
      next_prdata  = prdata;
      if (wr_ctrl)
         next_ctrl = pwdata[`SSF_CTRL_W-1:0];
      // a status write stores nothing; its only effect is the overrun clear
      if (apb_setup) begin
         next_prdata = '0;
         unique case (paddr)
            `SSF_STATUS_ADDR: next_prdata = {24'h000000, st};
            `SSF_RXDATA_ADDR: next_prdata = {24'h000000, rx_mem[rx_read_ptr]};
            `SSF_TXDATA_ADDR: next_prdata = {24'h000000, tx_mem[tx_write_ptr]};
            `SSF_CTRL_ADDR:   next_prdata = {28'h0000000, ctrl};
            default:          next_pslverr = 1'b1;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st           <= '{rx_overrun_flag: 1'b0, rx_not_empty_flag: 1'b0, tx_full_flag: 1'b0,
                           tx_empty_flag: 1'b1, tx_flush_flag: 1'b0,
                           expander_detect_flag: 1'b0, reserved: 2'b00};
         ctrl         <= `SSF_CTRL_RST;
         rx_write_ptr <= `SSF_PTR_ZERO;
         rx_read_ptr  <= `SSF_PTR_ZERO;
         tx_write_ptr <= `SSF_PTR_ZERO;
         tx_read_ptr  <= `SSF_PTR_ZERO;
         rx_cnt       <= `SSF_CNT_ZERO;
         tx_cnt       <= `SSF_CNT_ZERO;
         for (int i = 0; i < DEPTH; i++) begin
            rx_mem[i] <= 8'h00;
            tx_mem[i] <= 8'h00;
         end
         rx_shift  <= 8'h00;
         tx_shift  <= `SSF_IDLE_BYTE;
         bit_cnt   <= `SSF_BITS_ZERO;
         tx_loaded <= 1'b0;
         tx_busy   <= 1'b0;
         exp_mode  <= 1'b0;
         exp_done  <= 1'b0;
         prdata    <= 32'h00000000;
         pready    <= 1'b0;
         pslverr   <= 1'b0;
         miso      <= 1'b1;
         miso_oe   <= 1'b0;
         rx_irq    <= 1'b0;
         tx_irq    <= 1'b0;
      end else begin
         st           <= next_st;
         ctrl         <= next_ctrl;
         rx_write_ptr <= next_rx_write_ptr;
         rx_read_ptr  <= next_rx_read_ptr;
         tx_write_ptr <= next_tx_write_ptr;
         tx_read_ptr  <= next_tx_read_ptr;
         rx_cnt       <= next_rx_cnt;
         tx_cnt       <= next_tx_cnt;
         rx_mem       <= next_rx_mem;
         tx_mem       <= next_tx_mem;
         rx_shift     <= next_rx_shift;
         tx_shift     <= next_tx_shift;
         bit_cnt      <= next_bit_cnt;
         tx_loaded    <= next_tx_loaded;
         tx_busy      <= next_tx_busy;
         exp_mode     <= next_exp_mode;
         exp_done     <= next_exp_done;
         prdata       <= next_prdata;
         pready       <= next_pready;
         pslverr      <= next_pslverr;
         miso         <= next_miso;
         miso_oe      <= next_miso_oe;
         rx_irq       <= next_rx_irq;
         tx_irq       <= next_tx_irq;
      end
   end
endmodule // ssf_top
`default_nettype wire

// file: verif/ssf_checker.sv
// port-level assertions for the spi status flag block
`timescale 1ns/1ns
`default_nettype none
`include "ssf_regs.svh"
module ssf_checker
   import ssf_pkg::*;
#(
   parameter int DEPTH = `SSF_FIFO_DEPTH
) (
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        sck,
   input wire logic        mosi,
   input wire logic        ss_n,
   input wire logic        miso,
   input wire logic        miso_oe,
   input wire logic        rx_irq,
   input wire logic        tx_irq
);
   logic [3:0] ctrl;
   logic [3:0] next_ctrl;
   logic       acc;
   assign acc = psel && penable && pready;
   // shadow of the control register, the irq gates are judged against it
   always_comb begin
      next_ctrl = ctrl;
      if (acc && pwrite && paddr == `SSF_CTRL_ADDR) begin
         next_ctrl = pwdata[3:0];
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl <= `SSF_CTRL_RST;
      end else begin
         ctrl <= next_ctrl;
      end
   end
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   a_pready_one:
      assert property (psel && !penable |=> pready ##1 !pready) else $error("bad pready");
   a_unmapped_err:
      assert property (acc && !(paddr inside {`SSF_STATUS_ADDR, `SSF_RXDATA_ADDR,
         `SSF_TXDATA_ADDR, `SSF_CTRL_ADDR}) |-> pslverr && prdata == 32'h0)
      else $error("unmapped access not refused");
   a_status_rsvd:
      assert property (acc && !pwrite && paddr == `SSF_STATUS_ADDR
         |-> prdata[31:8] == 24'h0 && prdata[1:0] == 2'h0) else $error("status spare bits");
   a_rx_irq_gate:
      assert property (ctrl[1:0] == 2'h0 && $past(ctrl[1:0]) == 2'h0 |-> !rx_irq)
      else $error("rx irq while disabled");
   a_tx_irq_gate:
      assert property (!ctrl[2] && !$past(ctrl[2]) |-> !tx_irq) else $error("tx irq masked");
   a_tx_irq_drop:
      assert property (acc && pwrite && paddr == `SSF_TXDATA_ADDR |-> ##2 !tx_irq)
      else $error("tx irq after push");
   a_oe_on:
      assert property (!ss_n [*5] |-> miso_oe) else $error("miso not driven");
   a_oe_off:
      assert property (ss_n [*5] |-> !miso_oe) else $error("miso driven unselected");
   c_status_clear: cover property (acc && pwrite && paddr == `SSF_STATUS_ADDR);
   c_overrun_irq: cover property (rx_irq && ctrl == 4'h1);
   c_frame: cover property ($rose(miso_oe));
endmodule // ssf_checker
bind ssf_top ssf_checker #(.DEPTH(DEPTH)) i_ssf_checker (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .sck(sck), .mosi(mosi), .ss_n(ss_n), .miso(miso), .miso_oe(miso_oe),
   .rx_irq(rx_irq), .tx_irq(tx_irq)
);
`default_nettype wire

// file: verif/ssf_spi_master.sv
// remote spi master model, mode 0, clock stands still between frames
`timescale 1ns/1ns
`default_nettype none
module ssf_spi_master #(
   parameter int HALF = 80
) (
   output var  logic sck,
   output var  logic mosi,
   output var  logic ss_n,
   input  wire logic miso,
   input  wire logic miso_oe
);
   initial begin
      sck = 1'h0;
      mosi = 1'h1;
      ss_n = 1'h1;
   end
   // odd offset keeps pin edges off the core clock edges
   task automatic select(input logic m);
      #3 mosi = m;
      #HALF ss_n = 1'h0;
      #HALF;
   endtask
   task automatic xfer(input logic [7:0] d, output logic [7:0] q);
      for (int i = 7; i >= 0; i--) begin
         mosi = d[i];
         #HALF sck = 1'h1;
         q[i] = miso_oe ? miso : ~miso;
         #HALF sck = 1'h0;
      end
   endtask
   // released line shows no stale value
   task automatic deselect();
      #HALF ss_n = 1'h1;
      mosi = ~mosi;
      #HALF;
   endtask
endmodule // ssf_spi_master
`default_nettype wire

// file: verif/ssf_top_test.sv
// self-checking testbench for the spi status flag block
`timescale 1ns/1ns
`default_nettype none
`include "ssf_regs.svh"
module ssf_top_test
   import ssf_pkg::*;
;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
   logic        sck, mosi, ss_n, miso, miso_oe, rx_irq, tx_irq;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [7:0]  q, b, txb [12], rxb [13];
   int          num_errors = 0, tests_run = 0;
   initial begin
      pclk = 1'h0;
      forever #5 pclk = ~pclk;
   end
   ssf_top #(.DEPTH(12)) i_ssf_top (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .sck(sck), .mosi(mosi), .ss_n(ss_n), .miso(miso), .miso_oe(miso_oe),
      .rx_irq(rx_irq), .tx_irq(tx_irq));
   ssf_spi_master i_ssf_spi_master (
      .sck(sck), .mosi(mosi), .ss_n(ss_n), .miso(miso), .miso_oe(miso_oe));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         num_errors++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // flags in status order: overrun, not empty, full, empty, flush, expander
   function automatic logic [31:0] st(input logic [5:0] f);
      ssf_status_t s;
      s = ssf_status_t'({f, 2'h0});
      return {24'h0, s};
   endfunction
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'h1;
      do @(posedge pclk); while (pready !== 1'h1);
      rd = prdata;
      err = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
   endtask
   task automatic complete_run();
      $display("comparisons %0d mismatches %0d", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   initial begin
      #200000;
      num_errors++;
      complete_run();
   end
   initial begin
      {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
      void'($urandom(79));
      repeat (10) @(posedge pclk);
      presetn <= 1'h1;
      apb(1'h0, `SSF_STATUS_ADDR, 32'h0);
      chk(rd, st(6'h04));
      apb(1'h0, 12'h004, 32'h0);
      chk({err, rd[30:0]}, 32'h80000000);
      apb(1'h1, `SSF_STATUS_ADDR, $urandom);
      apb(1'h0, `SSF_STATUS_ADDR, 32'h0);
      chk(rd, st(6'h04));
      apb(1'h1, `SSF_CTRL_ADDR, 32'h6);
      apb(1'h0, `SSF_STATUS_ADDR, 32'h0);
      chk(tx_irq, 1'h1);
      for (int i = 0; i < 12; i++) begin
         txb[i] = 8'($urandom);
         apb(1'h1, `SSF_TXDATA_ADDR, {24'h0, txb[i]});
      end
      apb(1'h1, `SSF_TXDATA_ADDR, 32'hA5);
      apb(1'h0, `SSF_STATUS_ADDR, 32'h0);
      chk(rd, st(6'h08));
      i_ssf_spi_master.select(1'h1);
      // the thirteenth byte meets a full receive fifo and an empty transmit fifo
      for (int i = 0; i < 13; i++) begin
         rxb[i] = 8'($urandom);
         i_ssf_spi_master.xfer(rxb[i], q);
         chk(q, i < 12 ? txb[i] : 8'hFF);
      end
      i_ssf_spi_master.deselect();
      apb(1'h0, `SSF_STATUS_ADDR, 32'h0);
      chk(rd, st(6'h34));
      chk(rx_irq, 1'h1);
      apb(1'h1, `SSF_CTRL_ADDR, 32'h1);
      apb(1'h0, `SSF_STATUS_ADDR, 32'h0);
      chk(rx_irq, 1'h1);
      for (int i = 0; i < 5; i++) begin
         apb(1'h0, `SSF_RXDATA_ADDR, 32'h0);
         chk(rd, rxb[i]);
      end
      apb(1'h1, `SSF_STATUS_ADDR, $urandom);
      apb(1'h0, `SSF_STATUS_ADDR, 32'h0);
      chk(rd, st(6'h04));
      chk(rx_irq, 1'h0);
      apb(1'h1, `SSF_TXDATA_ADDR, $urandom);
      apb(1'h1, `SSF_TXDATA_ADDR, $urandom);
      i_ssf_spi_master.select(1'h1);
      i_ssf_spi_master.deselect();
      apb(1'h0, `SSF_STATUS_ADDR, 32'h0);
      chk(rd, st(6'h06));
      b = 8'($urandom);
      apb(1'h1, `SSF_TXDATA_ADDR, {24'h0, b});
      apb(1'h0, `SSF_STATUS_ADDR, 32'h0);
      chk(rd, st(6'h00));
      rxb[0] = 8'($urandom);
      i_ssf_spi_master.select(1'h1);
      i_ssf_spi_master.xfer(rxb[0], q);
      chk(q, b);
      i_ssf_spi_master.deselect();
      apb(1'h0, `SSF_STATUS_ADDR, 32'h0);
      chk(rd, st(6'h14));
      apb(1'h0, `SSF_RXDATA_ADDR, 32'h0);
      chk(rd, rxb[0]);
      apb(1'h0, `SSF_STATUS_ADDR, 32'h0);
      chk(rd, st(6'h04));
      // a core write lands at the read pointer and moves neither pointer
      b = 8'($urandom);
      apb(1'h1, `SSF_RXDATA_ADDR, {24'h0, b});
      apb(1'h0, `SSF_STATUS_ADDR, 32'h0);
      chk(rd, st(6'h04));
      apb(1'h0, `SSF_RXDATA_ADDR, 32'h0);
      chk(rd, {24'h0, b});
      apb(1'h1, `SSF_CTRL_ADDR, 32'h8);
      i_ssf_spi_master.select(1'h0);
      i_ssf_spi_master.xfer(8'($urandom), q);
      // select stays low until software has seen the flag
      apb(1'h0, `SSF_STATUS_ADDR, 32'h0);
      chk(rd, st(6'h05));
      i_ssf_spi_master.deselect();
      apb(1'h0, `SSF_STATUS_ADDR, 32'h0);
      chk(rd, st(6'h04));
      complete_run();
   end
endmodule // ssf_top_test
`default_nettype wire
